// ---- pulse_dialer_with_redial.sv ----
`timescale 1ns/1ps
module pulse_dialer_with_redial
  import dialer_pkg::*;
#(
  parameter int TICK_DIV = `MCLK_HZ / `OSC_HZ
) (
  // Clock and power-up clear
  input wire logic mclk,
  input wire logic rst_n,
  // Hook switch and ratio strap
  input wire logic hook_sense,
  input wire logic ratio_sel,
  // Keypad rows
  input wire logic [3:0] row_in,
  output logic [3:0] row_out,
  output logic [3:0] row_oe,
  // Keypad columns
  input wire logic [2:0] col_in,
  output logic [2:0] col_out,
  output logic [2:0] col_oe,
  // Line break and receiver mute, open drain
  output logic line_break_out,
  output logic line_break_oe,
  output logic mute_out,
  output logic mute_oe
);
  dialer_s s, n;
  key_link_if kl();
  logic onhook, off_edge, pending, drain_done, is_special;
  logic [10:0] brk_len, mk_len;

  // ********************************
  // Key scanner
  // ********************************
  keypad_scan u_scan (
    .mclk(mclk),
    .rst_n(rst_n),
    .kl(kl.scanner)
  );

  assign kl.tick = s.tick;
  assign kl.onhook = s.hs2;
  assign kl.scan_en = s.osc_on && !s.hs2;
  assign kl.row_s = s.row2;
  assign kl.col_s = s.col2;
  assign row_out = kl.row_out;
  assign row_oe = kl.row_oe;
  assign col_out = kl.col_out;
  assign col_oe = kl.col_oe;

  // Open-drain pins only ever pull low
  assign line_break_out = 1'b0;
  assign mute_out = 1'b0;
  assign line_break_oe = s.line_oe;
  assign mute_oe = s.mute_oe;

  // ********************************
  // Next state
  // ********************************
  always_comb begin
    n = s;
    n.tick = 1'b0;
    n.hs1 = hook_sense;
    n.hs2 = s.hs1;
    n.rs1 = ratio_sel;
    n.rs2 = s.rs1;
    n.row1 = row_in;
    n.row2 = s.row1;
    n.col1 = col_in;
    n.col2 = s.col1;
    n.hook_prev = s.hs2;

    onhook = s.hs2;
    off_edge = s.hook_prev && !s.hs2;
    pending = s.rd != s.wr;
    is_special = (kl.code == `KEY_STAR) || (kl.code == `KEY_HASH);
    brk_len = s.rs2 ? 11'(`BREAK_HI_TICKS) : 11'(`BREAK_LO_TICKS);
    mk_len = s.rs2 ? 11'(`MAKE_HI_TICKS) : 11'(`MAKE_LO_TICKS);

    // Oscillator model: a tick per oscillator cycle, only while running
    if (s.osc_on || s.blip) begin
      if (s.pre == 17'(TICK_DIV - 1)) begin
        n.pre = 17'h0;
        n.tick = 1'b1;
      end else begin
        n.pre = s.pre + 17'h1;
      end
    end else begin
      n.pre = 17'h0;
    end
    if (!onhook && kl.sensed) begin
      n.osc_on = 1'b1;
    end

    // Returning off-hook: a short mute pulse for one oscillator cycle
    if (off_edge) begin
      n.mute_oe = 1'b1;
      n.blip = 1'b1;
      n.hook_tmr = 10'h0;
    end else if (s.tick && s.blip) begin
      n.blip = 1'b0;
      if (s.st == ST_IDLE) begin
        n.mute_oe = 1'b0;
      end
    end

    // ********************************
    // Outpulsing
    // ********************************
    case (s.st)
      ST_IDLE: begin
        if (pending && !onhook) begin
          n.st = ST_PAUSE;
          n.tmr = 11'h0;
          n.mute_oe = 1'b1;
        end
      end
      ST_PAUSE: begin
        if (s.tick) begin
          if (s.tmr == 11'(`GAP_TICKS - 1)) begin
            n.st = ST_BRK;
            n.tmr = 11'h0;
            n.line_oe = 1'b1;
            n.dig = s.mem[s.rd[4:0]];
            n.pcnt = s.mem[s.rd[4:0]];
            n.rd = s.rd + 6'h1;
          end else begin
            n.tmr = s.tmr + 11'h1;
          end
        end
      end
      ST_BRK: begin
        if (s.tick) begin
          if (s.tmr == brk_len - 11'h1) begin
            n.line_oe = 1'b0;
            n.tmr = 11'h0;
            if (s.pcnt == 4'h1) begin
              n.st = pending ? ST_PAUSE : ST_OVER;
            end else begin
              n.st = ST_MAKE;
              n.pcnt = s.pcnt - 4'h1;
            end
          end else begin
            n.tmr = s.tmr + 11'h1;
          end
        end
      end
      ST_MAKE: begin
        if (s.tick) begin
          if (s.tmr == mk_len - 11'h1) begin
            n.st = ST_BRK;
            n.tmr = 11'h0;
            n.line_oe = 1'b1;
          end else begin
            n.tmr = s.tmr + 11'h1;
          end
        end
      end
      ST_OVER: begin
        if (pending && !onhook) begin
          n.st = ST_PAUSE;
          n.tmr = 11'h0;
        end else if (s.tick) begin
          if (s.tmr == 11'(`OVERLAP_TICKS - 1)) begin
            n.st = ST_IDLE;
            n.mute_oe = 1'b0;
          end else begin
            n.tmr = s.tmr + 11'h1;
          end
        end
      end
      default: begin
        n.st = ST_IDLE;
        n.line_oe = 1'b0;
      end
    endcase

    // ********************************
    // Key entry
    // ********************************
    // Entries land here in any state, so digits queue behind the pulse train
    if (kl.strobe && !onhook) begin
      if (is_special) begin
        if (s.first) begin
          n.rd = `COUNT_RESET;
          n.first = 1'b0;
        end
      end else if (s.first) begin
        n.mem[0] = kl.code;
        n.wr = 6'h01;
        n.rd = `COUNT_RESET;
        n.first = 1'b0;
      end else if (s.wr < 6'(`DIAL_DEPTH)) begin
        n.mem[s.wr[4:0]] = kl.code;
        n.wr = s.wr + 6'h1;
      end
    end
    // Later star or hash keys fall through above without being stored

    // ********************************
    // On-hook drain and shutdown
    // ********************************
    // The current digit may finish, but no new one starts; the timer caps the wait
    if (onhook) begin
      n.first = 1'b1;
      if (s.tick && s.hook_tmr != 10'(`DRAIN_TICKS)) begin
        n.hook_tmr = s.hook_tmr + 10'h1;
      end
    end
    drain_done = onhook && (s.st == ST_IDLE || s.st == ST_PAUSE || s.st == ST_OVER ||
                            s.hook_tmr == 10'(`DRAIN_TICKS));
    if (drain_done) begin
      n.st = ST_IDLE;
      n.osc_on = 1'b0;
      n.blip = 1'b0;
      n.line_oe = 1'b0;
      n.mute_oe = 1'b0;
      n.rd = s.wr;
      n.tmr = 11'h0;
    end
  end

  // Power-up clear: empties memory so redial cannot send stale digits
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      s <= '0;
      s.hs1 <= 1'b1;
      s.hs2 <= 1'b1;
      s.hook_prev <= 1'b1;
      s.first <= 1'b1;
      s.line_oe <= `DRIVE_RESET;
      s.mute_oe <= `DRIVE_RESET;
      s.wr <= `COUNT_RESET;
      s.rd <= `COUNT_RESET;
    end else begin
      s <= n;
    end
  end

  // ********************************
  // Checks
  // ********************************
  logic [11:0] dwell;
  logic [3:0] brk_n;
  always_ff @(posedge mclk) begin
    if (!rst_n || s.st != n.st) begin
      dwell <= 12'h0;
    end else if (s.tick) begin
      dwell <= dwell + 12'h1;
    end
    if (!rst_n) begin
      brk_n <= 4'h0;
    end else if (s.st != ST_BRK && n.st == ST_BRK) begin
      brk_n <= (s.st == ST_PAUSE) ? 4'h1 : brk_n + 4'h1;
    end else if (s.st == ST_PAUSE) begin
      brk_n <= 4'h0;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  a_break_pin: assert property (line_break_oe == (s.st == ST_BRK))
    else $error("line break drive out of step with break state");
  a_mute_cover: assert property (line_break_oe |-> mute_oe)
    else $error("line pulsed while receiver not muted");
  a_depth_limit: assert property (s.wr <= 6'(`DIAL_DEPTH))
    else $error("dial memory count beyond depth");
  a_mute_offhook: assert property ($fell(s.hs2) |=> mute_oe)
    else $error("no mute pulse on return off-hook");
  a_quiet_onhook: assert property (s.hs2 && !s.osc_on && !s.blip |=> !s.tick)
    else $error("oscillator running while on-hook");
  a_make_len: assert property (s.st == ST_MAKE && n.st == ST_BRK |-> dwell == 12'(mk_len - 11'h1))
    else $error("make interval has wrong length");
  a_gap_len: assert property (s.st == ST_PAUSE && n.st == ST_BRK |-> dwell == 12'(`GAP_TICKS - 1))
    else $error("inter-digit pause has wrong length");
  a_pulse_count: assert property (s.st == ST_BRK && !s.hs2 && (n.st == ST_PAUSE || n.st == ST_OVER)
                                  |-> brk_n == s.dig)
    else $error("break count differs from digit value");
  a_redial_start: assert property (kl.strobe && !s.hs2 && s.first && is_special
                                   |=> s.rd == 6'h00 && !s.first)
    else $error("redial did not restart memory");
  a_new_number: assert property (kl.strobe && !s.hs2 && s.first && !is_special
                                 |=> s.wr == 6'h01 && s.mem[0] == $past(kl.code))
    else $error("new number did not replace memory");
  a_drain_end: assert property (s.hs2 && s.hook_tmr == 10'(`DRAIN_TICKS) |=> !s.osc_on && !line_break_oe)
    else $error("activity continued after on-hook drain limit");
endmodule : pulse_dialer_with_redial

// ---- pulse_dialer_map.svh ----
`ifndef PULSE_DIALER_MAP_SVH
`define PULSE_DIALER_MAP_SVH
// Behaviour
// - Hook input low means off-hook
// - On-hook: finish pulsing within 300 ms, sleep
// - Off-hook return pulls mute low
// - First key star or hash redials memory
// - Other first key restarts memory, dials
// - Line output released in make, low in break
// - On-hook: oscillator stopped, keys ignored
// - Keep only first 32 digits
// - Accept keys while earlier digits pulse out
// - Pulse until all stored digits dialed
// - Valid key: exactly one row, one column
// - On-hook: rows and columns held high
// - Static until key sensed, then scan
// - Key must stay valid 14 to 20 ms
// - Ratio pin selects 33.4 or 40 percent make
// - Mute from pause until overlap after break
// - Power-up clear empties redial memory

// ********************************
// Clocks and time base
// ********************************
`define MCLK_HZ 200000000
`define OSC_HZ 2400
`define TICKS_UP(ms) ((((ms) * `OSC_HZ) + 999) / 1000)
`define TICKS_DN(ms) (((ms) * `OSC_HZ) / 1000)

// ********************************
// Timing
// ********************************
`define MEMORY_CLEAR_HOLD_TIME_MS 300
`define DRAIN_TICKS `TICKS_DN(`MEMORY_CLEAR_HOLD_TIME_MS)
`define KEY_DEBOUNCE_TIME_MS 14
`define KEY_DEBOUNCE_MAX_MS 20
`define SCAN_PHASES 4
`define DEBOUNCE_EVALS ((`TICKS_UP(`KEY_DEBOUNCE_TIME_MS) + `SCAN_PHASES - 1) / `SCAN_PHASES)
`define INTERDIGIT_GAP_TIME_MS 800
`define GAP_TICKS `TICKS_DN(`INTERDIGIT_GAP_TIME_MS)
`define SILENCE_OVERLAP_TIME_MS 5
`define OVERLAP_TICKS `TICKS_UP(`SILENCE_OVERLAP_TIME_MS)
`define PULSE_PERIOD_MS 100
`define PERIOD_TICKS `TICKS_DN(`PULSE_PERIOD_MS)
`define MAKE_HI_PERMIL 334
`define MAKE_LO_PERMIL 400
`define MAKE_HI_TICKS ((`PERIOD_TICKS * `MAKE_HI_PERMIL) / 1000)
`define MAKE_LO_TICKS ((`PERIOD_TICKS * `MAKE_LO_PERMIL) / 1000)
`define BREAK_HI_TICKS (`PERIOD_TICKS - `MAKE_HI_TICKS)
`define BREAK_LO_TICKS (`PERIOD_TICKS - `MAKE_LO_TICKS)

// ********************************
// Memory, key codes, reset values
// ********************************
`define DIAL_DEPTH 32
`define KEY_ZERO 4'hA
`define KEY_STAR 4'hB
`define KEY_HASH 4'hC
`define DRIVE_RESET 1'b0
`define COUNT_RESET 6'h00
`endif

// ---- dialer_pkg.sv ----
package dialer_pkg;
  `include "pulse_dialer_map.svh"

  typedef logic [3:0] key_code_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_PAUSE = 3'h1,
    ST_BRK = 3'h3,
    ST_MAKE = 3'h2,
    ST_OVER = 3'h6
  } dial_state_e;

  typedef struct packed {
    logic hs1, hs2, hook_prev, rs1, rs2;
    logic [3:0] row1, row2;
    logic [2:0] col1, col2;
    logic osc_on, blip, first, tick;
    logic [16:0] pre;
    dial_state_e st;
    logic [10:0] tmr;
    logic [9:0] hook_tmr;
    logic [`DIAL_DEPTH-1:0][3:0] mem;
    logic [5:0] wr, rd;
    logic [3:0] pcnt, dig;
    logic line_oe, mute_oe;
  } dialer_s;

  typedef struct packed {
    logic [1:0] phase;
    logic [3:0] rows_lat;
    logic [3:0] stab;
    key_code_t code_prev;
    logic held, strobe;
    key_code_t code;
  } scan_s;
endpackage : dialer_pkg

// ---- key_link_if.sv ----
`timescale 1ns/1ps
interface key_link_if;
  logic tick, scan_en, onhook, strobe, sensed;
  logic [3:0] row_s, row_out, row_oe;
  logic [2:0] col_s, col_out, col_oe;
  logic [3:0] code;
  modport dialer(output tick, scan_en, onhook, row_s, col_s,
                 input strobe, sensed, code, row_out, row_oe, col_out, col_oe);
  modport scanner(input tick, scan_en, onhook, row_s, col_s,
                  output strobe, sensed, code, row_out, row_oe, col_out, col_oe);
endinterface : key_link_if

// ---- keypad_scan.sv ----
`timescale 1ns/1ps
module keypad_scan
  import dialer_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Link to the dialer
  key_link_if.scanner kl
);
  scan_s s, n;
  logic [3:0] rows_low;
  logic [2:0] cols_low;

  // ********************************
  // Key decode
  // ********************************
  function automatic key_code_t key_map(input logic [3:0] r, input logic [2:0] c);
    logic [3:0] idx;
    idx = 4'h0;
    for (int i = 0; i < 4; i++) begin
      if (r[i]) idx = idx + 4'(i * 3);
    end
    for (int j = 0; j < 3; j++) begin
      if (c[j]) idx = idx + 4'(j);
    end
    case (idx)
      4'h9: key_map = `KEY_STAR;
      4'hA: key_map = `KEY_ZERO;
      4'hB: key_map = `KEY_HASH;
      default: key_map = idx + 4'h1;
    endcase
  endfunction : key_map

  assign rows_low = ~kl.row_s;
  assign cols_low = ~kl.col_s;
  assign kl.sensed = !kl.onhook && ((|rows_low) || (|cols_low));
  assign kl.strobe = s.strobe;
  assign kl.code = s.code;

  always_comb begin
    n = s;
    n.strobe = 1'b0;
    if (!kl.scan_en) begin
      n.phase = 2'h0;
      n.stab = 4'h0;
      n.held = 1'b0;
    end else if (kl.tick) begin
      n.phase = s.phase + 2'h1;
      if (s.phase == 2'h1) begin
        n.rows_lat = rows_low;
      end
      if (s.phase == 2'h3) begin
        if ($onehot(s.rows_lat) && $onehot(cols_low)) begin
          n.code_prev = key_map(s.rows_lat, cols_low);
          if (n.code_prev == s.code_prev && s.stab != 4'h0) begin
            n.stab = (s.stab == 4'hF) ? s.stab : s.stab + 4'h1;
          end else begin
            n.stab = 4'h1;
          end
          if (n.stab == 4'(`DEBOUNCE_EVALS) && !s.held) begin
            n.strobe = 1'b1;
            n.held = 1'b1;
            n.code = n.code_prev;
          end
        end else begin
          n.stab = 4'h0;
          n.held = 1'b0;
        end
      end
    end
  end

  // Each half of the matrix is pulled high, then low, while the other half is read
  always_comb begin
    kl.row_out = 4'hF;
    kl.col_out = 3'h7;
    kl.row_oe = 4'h0;
    kl.col_oe = 3'h0;
    if (kl.onhook) begin
      kl.row_oe = 4'hF;
      kl.col_oe = 3'h7;
    end else if (kl.scan_en) begin
      case (s.phase)
        2'h0: kl.col_oe = 3'h7;
        2'h1: begin
          kl.col_oe = 3'h7;
          kl.col_out = 3'h0;
        end
        2'h2: kl.row_oe = 4'hF;
        2'h3: begin
          kl.row_oe = 4'hF;
          kl.row_out = 4'h0;
        end
        default: kl.row_oe = 4'h0;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  a_keys_onhook: assert property (kl.onhook && $past(kl.onhook) |-> !kl.strobe)
    else $error("key accepted while on-hook");
  a_lines_high: assert property (kl.onhook |-> (&kl.row_oe) && (&kl.row_out) && (&kl.col_oe) && (&kl.col_out))
    else $error("keypad lines not held high on-hook");
  a_debounce_min: assert property (kl.strobe |-> $past(s.stab) == 4'(`DEBOUNCE_EVALS - 1) && s.held)
    else $error("key accepted before debounce");
endmodule : keypad_scan

// ---- keypad_line_model.sv ----
`timescale 1ns/1ps
module keypad_line_model (
  // Test controls
  input wire logic off_hook,
  input wire logic key_down,
  input wire logic [3:0] key_idx,
  // Dialer pins
  input wire logic [3:0] row_out,
  input wire logic [3:0] row_oe,
  input wire logic [2:0] col_out,
  input wire logic [2:0] col_oe,
  input wire logic line_break_out,
  input wire logic line_break_oe,
  input wire logic mute_out,
  input wire logic mute_oe,
  // Resolved wires
  output logic hook_sense,
  output logic [3:0] row_in,
  output logic [2:0] col_in,
  output logic line_n,
  output logic mute_n
);
  // ********************************
  // Negative common keypad, pull-ups everywhere
  // ********************************
  // A pressed key grounds its row and column hard, so it wins over any drive
  always_comb begin
    hook_sense = ~off_hook;
    for (int r = 0; r < 4; r++) begin
      row_in[r] = (row_oe[r] ? row_out[r] : 1'b1) & ~(key_down && (key_idx / 3) == r);
    end
    for (int c = 0; c < 3; c++) begin
      col_in[c] = (col_oe[c] ? col_out[c] : 1'b1) & ~(key_down && (key_idx % 3) == c);
    end
    line_n = line_break_oe ? line_break_out : 1'b1;
    mute_n = mute_oe ? mute_out : 1'b1;
  end
endmodule : keypad_line_model

// ---- pulse_dialer_with_redial_tb.sv ----
`timescale 1ns/1ps
module pulse_dialer_with_redial_tb;
  import dialer_pkg::*;
  localparam int TD = 4;
  typedef struct {int pulses; int brk; int mk;} train_s;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic off_hook = 1'b0;
  logic key_down = 1'b0;
  logic [3:0] key_idx = 4'h0;
  logic ratio_sel = 1'b0;
  logic hook_sense, line_break_out, line_break_oe, mute_out, mute_oe, line_n, mute_n;
  logic [3:0] row_in, row_out, row_oe;
  logic [2:0] col_in, col_out, col_oe;
  int mismatches = 0;
  int total_checks = 0;
  int cyc = 0, ref_c = 0, end_c = 0, pulses = 0, brk = 0, mk = 0;
  logic in_train = 1'b0, line_q = 1'b1, mute_q = 1'b1;
  train_s t;
  train_s exp_q[$];

  always #2.5 mclk = ~mclk;

  pulse_dialer_with_redial #(.TICK_DIV(TD)) dut_u (.mclk(mclk), .rst_n(rst_n), .hook_sense(hook_sense),
    .ratio_sel(ratio_sel), .row_in(row_in), .row_out(row_out), .row_oe(row_oe), .col_in(col_in),
    .col_out(col_out), .col_oe(col_oe), .line_break_out(line_break_out), .line_break_oe(line_break_oe),
    .mute_out(mute_out), .mute_oe(mute_oe));
  keypad_line_model model_u (.off_hook(off_hook), .key_down(key_down), .key_idx(key_idx),
    .row_out(row_out), .row_oe(row_oe), .col_out(col_out), .col_oe(col_oe), .line_break_out(line_break_out),
    .line_break_oe(line_break_oe), .mute_out(mute_out), .mute_oe(mute_oe), .hook_sense(hook_sense),
    .row_in(row_in), .col_in(col_in), .line_n(line_n), .mute_n(mute_n));

  // ********************************
  // Helpers
  // ********************************
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : finish_test

  // Rounded to whole ticks: mute falls a cycle or two off the tick grid
  function automatic int ticks(input int c);
    return (c + TD / 2) / TD;
  endfunction : ticks

  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : step

  task automatic press(input int idx, input int hold, output int lat);
    key_idx = idx[3:0];
    key_down = 1'b1;
    lat = -1;
    for (int i = 1; i <= hold * TD; i++) begin
      step(1);
      if (!mute_n && lat < 0) lat = i;
    end
    key_down = 1'b0;
    step(40 * TD);
  endtask : press

  function automatic void expect_digit(input int d);
    train_s e;
    e.pulses = d;
    e.brk = ratio_sel ? `BREAK_HI_TICKS : `BREAK_LO_TICKS;
    e.mk = ratio_sel ? `MAKE_HI_TICKS : `MAKE_LO_TICKS;
    exp_q.push_back(e);
  endfunction : expect_digit

  task automatic wait_done();
    int n;
    n = 0;
    while ((exp_q.size() != 0 || in_train) && n < 40000) begin
      step(1);
      n++;
    end
    check("trains done", exp_q.size(), 0);
  endtask : wait_done

  task automatic go_on_hook();
    off_hook = 1'b0;
    step(750 * TD);
    check("line released", line_break_oe, 1'b0);
    check("mute released", mute_oe, 1'b0);
    check("rows held high", {row_oe, row_out}, 8'hFF);
    check("cols held high", {col_oe, col_out}, 6'h3F);
  endtask : go_on_hook

  task automatic go_off_hook();
    int n;
    n = 0;
    off_hook = 1'b1;
    while (mute_n && n < 10) begin
      step(1);
      n++;
    end
    check("mute blip", mute_n, 1'b0);
    step(3 * TD);
    check("mute reconnect", mute_n, 1'b1);
    check("keypad static", {row_oe, col_oe}, 7'h00);
  endtask : go_off_hook

  // ********************************
  // Line monitor
  // ********************************
  // Sampled mid-cycle so every output has settled after its launching edge
  always @(negedge mclk) begin
    cyc++;
    if (!rst_n) begin
      in_train = 1'b0;
      pulses = 0;
    end else begin
      if (!mute_n && mute_q && !in_train) ref_c = cyc;
      if (mute_n && !mute_q && in_train) check("mute overlap", ticks(cyc - end_c), `OVERLAP_TICKS);
      if (!line_n && line_q) begin
        if (!in_train) check("digit gap", ticks(cyc - ref_c), `GAP_TICKS);
        if (in_train) mk = cyc - end_c;
        check("mute in break", mute_n, 1'b0);
        in_train = 1'b1;
        pulses++;
        ref_c = cyc;
      end
      if (line_n && !line_q) begin
        brk = cyc - ref_c;
        end_c = cyc;
        ref_c = cyc;
      end
      if (in_train && line_n && cyc - end_c == 200 * TD) begin
        if (exp_q.size() == 0) begin
          check("unexpected train", pulses, 0);
        end else begin
          t = exp_q.pop_front();
          check("pulse count", pulses, t.pulses);
          check("break length", ticks(brk), t.brk);
          if (t.pulses > 1) check("make length", ticks(mk), t.mk);
        end
        in_train = 1'b0;
        pulses = 0;
      end
    end
    line_q = line_n;
    mute_q = mute_n;
  end

  // ********************************
  // Scenarios
  // ********************************
  initial begin
    int lat, d;
    void'($urandom(32'h1024));
    ratio_sel = 1'($urandom % 2);
    d = $urandom % 5 + 1;
    step(5);
    rst_n = 1'b1;
    check("break pin level", line_break_out, 1'b0);
    check("rows high after clear", {row_oe, row_out}, 8'hFF);
    press(1, 60, lat);
    check("on-hook key ignored", mute_oe, 1'b0);
    go_off_hook();
    press(4, 25, lat);
    check("short press", mute_n, 1'b1);
    press(1, 60, lat);
    check("debounce window", lat >= 34 * TD && lat <= 48 * TD, 1'b1);
    expect_digit(2);
    press(9, 60, lat);
    press(10, 60, lat);
    expect_digit(10);
    wait_done();
    // Replay on the other ratio, hang up in the pause before the zero
    go_on_hook();
    ratio_sel = ~ratio_sel;
    go_off_hook();
    press(11, 60, lat);
    expect_digit(2);
    wait_done();
    go_on_hook();
    // A new first digit replaces the stored number
    go_off_hook();
    press(d - 1, 60, lat);
    expect_digit(d);
    wait_done();
    go_on_hook();
    go_off_hook();
    press(9, 60, lat);
    expect_digit(d);
    wait_done();
    // Power-up clear leaves nothing to redial
    rst_n = 1'b0;
    step(5);
    rst_n = 1'b1;
    go_off_hook();
    press(11, 60, lat);
    step(2000 * TD);
    check("no stale redial", mute_n, 1'b1);
    finish_test();
  end

  initial begin
    // About 21000 ticks of scenarios; the margin stays under the run budget
    step(95000);
    mismatches++;
    finish_test();
  end
endmodule : pulse_dialer_with_redial_tb
